/* src/glb_consts.vh */
`ifndef GLB_CONSTS_VH
`define GLB_CONSTS_VH

// Local bus addresses, port A
`define GLB_PA_DEN_WR 32'h40000040
`define GLB_PA_DEN_SET 32'h40000044
`define GLB_PA_DEN_CLR 32'h40000048
`define GLB_PA_DEN_TGL 32'h4000004C
`define GLB_PA_LVL_WR 32'h40000050
`define GLB_PA_LVL_SET 32'h40000054
`define GLB_PA_LVL_CLR 32'h40000058
`define GLB_PA_LVL_TGL 32'h4000005C
`define GLB_PA_PIN 32'h40000060

// Local bus addresses, port B
`define GLB_PB_DEN_WR 32'h40000140
`define GLB_PB_DEN_SET 32'h40000144
`define GLB_PB_DEN_CLR 32'h40000148
`define GLB_PB_DEN_TGL 32'h4000014C
`define GLB_PB_LVL_WR 32'h40000150
`define GLB_PB_LVL_SET 32'h40000154
`define GLB_PB_LVL_CLR 32'h40000158
`define GLB_PB_LVL_TGL 32'h4000015C
`define GLB_PB_PIN 32'h40000160

// Access modes
`define GLB_OP_WRITE 2'h0
`define GLB_OP_SET 2'h1
`define GLB_OP_CLEAR 2'h2
`define GLB_OP_TOGGLE 2'h3

// Register selects
`define GLB_SEL_DEN 2'h0
`define GLB_SEL_LVL 2'h1
`define GLB_SEL_PIN 2'h2

// Reset values
`define GLB_DEN_RST 32'h00000000
`define GLB_LVL_RST 32'h00000000
`define GLB_PIN_RST 32'h00000000
`define GLB_RDATA_RST 32'h00000000

`endif

/* src/glb_pin_sample.v */
`timescale 1ns/1ps
`default_nettype none
`include "glb_consts.vh"

module glb_pin_sample #(
    parameter W = 32
) (
    input wire clk_in,
    input wire nrst_in,
    input wire ce_in,
    input wire [W-1:0] pin_in,
    output reg [W-1:0] level_out
);

    localparam [31:0] RST_32 = `GLB_PIN_RST;
    localparam [W-1:0] RST_W = RST_32[W-1:0];

    // Pins are synchronous; one register stage holds the sampled levels
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            level_out <= RST_W;
        end else if (ce_in) begin
            level_out <= pin_in;
        end
    end

endmodule // glb_pin_sample

`default_nettype wire

/* src/glb_port.v */
// Behaviour
// [RULE1] Registers shared by peripheral and local bus
// [RULE2] Local bus has only CPU and this slave
// [RULE3] Local bus slave runs on CPU clock
// [RULE4] One access per cycle, no wait states
// [RULE5] Port A enable: write, set, clear aliases
// [RULE6] Port A enable toggle alias after clear
// [RULE7] Port A output level: four write aliases
// [RULE8] Port A pin levels: one read address
// [RULE9] Port B same layout, 0x100 higher
// [RULE10] Set, clear, toggle, write act bitwise
// [RULE11] CPU writes aliases, reads only pin levels
`timescale 1ns/1ps
`default_nettype none
`include "glb_consts.vh"

module glb_port #(
    parameter W = 32
) (
    input wire clk_in,
    input wire nrst_in,
    input wire ce_in,

    // CPU local bus
    input wire [31:0] lb_addr_in,
    input wire lb_wr_in,
    input wire lb_rd_in,
    input wire [31:0] lb_wdata_in,
    output wire lb_ready_out,
    output reg [31:0] lb_rdata_out,
    output reg lb_rvalid_out,
    output reg lb_err_out,

    // Peripheral bus register path
    input wire pb_port_in,
    input wire [1:0] pb_sel_in,
    input wire [1:0] pb_op_in,
    input wire pb_wr_in,
    input wire pb_rd_in,
    input wire [31:0] pb_wdata_in,
    output reg [31:0] pb_rdata_out,
    output reg pb_rvalid_out,

    // Port A pins
    input wire [W-1:0] porta_pin_in,
    output wire [W-1:0] porta_pin_out,
    output wire [W-1:0] porta_pin_oe_out,

    // Port B pins
    input wire [W-1:0] portb_pin_in,
    output wire [W-1:0] portb_pin_out,
    output wire [W-1:0] portb_pin_oe_out
);

    localparam [31:0] RDATA_RST = `GLB_RDATA_RST;

    // Decode result: {hit, port, sel[1:0], op[1:0]}
    function [5:0] lb_decode;
        input [31:0] addr;
        begin
            case (addr)
                `GLB_PA_DEN_WR:
                    lb_decode = {1'b1, 1'b0, `GLB_SEL_DEN, `GLB_OP_WRITE};
                `GLB_PA_DEN_SET:
                    lb_decode = {1'b1, 1'b0, `GLB_SEL_DEN, `GLB_OP_SET};
                `GLB_PA_DEN_CLR:
                    lb_decode = {1'b1, 1'b0, `GLB_SEL_DEN, `GLB_OP_CLEAR};
                `GLB_PA_DEN_TGL:
                    lb_decode = {1'b1, 1'b0, `GLB_SEL_DEN, `GLB_OP_TOGGLE};
                `GLB_PA_LVL_WR:
                    lb_decode = {1'b1, 1'b0, `GLB_SEL_LVL, `GLB_OP_WRITE};
                `GLB_PA_LVL_SET:
                    lb_decode = {1'b1, 1'b0, `GLB_SEL_LVL, `GLB_OP_SET};
                `GLB_PA_LVL_CLR:
                    lb_decode = {1'b1, 1'b0, `GLB_SEL_LVL, `GLB_OP_CLEAR};
                `GLB_PA_LVL_TGL:
                    lb_decode = {1'b1, 1'b0, `GLB_SEL_LVL, `GLB_OP_TOGGLE};
                `GLB_PA_PIN:
                    lb_decode = {1'b1, 1'b0, `GLB_SEL_PIN, `GLB_OP_WRITE};
                `GLB_PB_DEN_WR:
                    lb_decode = {1'b1, 1'b1, `GLB_SEL_DEN, `GLB_OP_WRITE};
                `GLB_PB_DEN_SET:
                    lb_decode = {1'b1, 1'b1, `GLB_SEL_DEN, `GLB_OP_SET};
                `GLB_PB_DEN_CLR:
                    lb_decode = {1'b1, 1'b1, `GLB_SEL_DEN, `GLB_OP_CLEAR};
                `GLB_PB_DEN_TGL:
                    lb_decode = {1'b1, 1'b1, `GLB_SEL_DEN, `GLB_OP_TOGGLE};
                `GLB_PB_LVL_WR:
                    lb_decode = {1'b1, 1'b1, `GLB_SEL_LVL, `GLB_OP_WRITE};
                `GLB_PB_LVL_SET:
                    lb_decode = {1'b1, 1'b1, `GLB_SEL_LVL, `GLB_OP_SET};
                `GLB_PB_LVL_CLR:
                    lb_decode = {1'b1, 1'b1, `GLB_SEL_LVL, `GLB_OP_CLEAR};
                `GLB_PB_LVL_TGL:
                    lb_decode = {1'b1, 1'b1, `GLB_SEL_LVL, `GLB_OP_TOGGLE};
                `GLB_PB_PIN:
                    lb_decode = {1'b1, 1'b1, `GLB_SEL_PIN, `GLB_OP_WRITE};
                default:
                    lb_decode = 6'h00;
            endcase
        end
    endfunction

    // Zero-extends a port-wide value onto the 32-bit data bus
    function [31:0] widen;
        input [W-1:0] val;
        begin
            widen = 32'h00000000;
            widen[W-1:0] = val;
        end
    endfunction

    wire [5:0] lb_dec;
    wire lb_hit;
    wire lb_port;
    wire [1:0] lb_sel;
    wire [1:0] lb_op;

    wire [W-1:0] porta_den;
    wire [W-1:0] porta_lvl;
    wire [W-1:0] porta_pins;
    wire [W-1:0] portb_den;
    wire [W-1:0] portb_lvl;
    wire [W-1:0] portb_pins;

    wire lb_wr_ok;
    wire lb_rd_ok;
    wire lb_bad;
    wire porta_den_lb_we;
    wire porta_lvl_lb_we;
    wire portb_den_lb_we;
    wire portb_lvl_lb_we;
    wire porta_den_pb_we;
    wire porta_lvl_pb_we;
    wire portb_den_pb_we;
    wire portb_lvl_pb_we;

    reg [31:0] lb_rdata_nxt;
    reg [31:0] pb_rdata_nxt;

    assign lb_dec = lb_decode(lb_addr_in); // [RULE5] [RULE6] [RULE7] [RULE9]
    assign lb_hit = lb_dec[5];
    assign lb_port = lb_dec[4];
    assign lb_sel = lb_dec[3:2];
    assign lb_op = lb_dec[1:0];

    // Writes go only to aliases, reads only to the pin level address
    assign lb_wr_ok = lb_wr_in && lb_hit
        && (lb_sel != `GLB_SEL_PIN); // [RULE11]
    assign lb_rd_ok = lb_rd_in && !lb_wr_in && lb_hit
        && (lb_sel == `GLB_SEL_PIN); // [RULE8] [RULE11]
    assign lb_bad = (lb_wr_in || lb_rd_in) && !lb_wr_ok && !lb_rd_ok;

    // Write enables per register, one set for each bus
    assign porta_den_lb_we = lb_wr_ok && !lb_port && (lb_sel == `GLB_SEL_DEN);
    assign porta_lvl_lb_we = lb_wr_ok && !lb_port && (lb_sel == `GLB_SEL_LVL);
    assign portb_den_lb_we = lb_wr_ok && lb_port && (lb_sel == `GLB_SEL_DEN);
    assign portb_lvl_lb_we = lb_wr_ok && lb_port && (lb_sel == `GLB_SEL_LVL);
    assign porta_den_pb_we = pb_wr_in && !pb_port_in
        && (pb_sel_in == `GLB_SEL_DEN); // [RULE1]
    assign porta_lvl_pb_we = pb_wr_in && !pb_port_in
        && (pb_sel_in == `GLB_SEL_LVL); // [RULE1]
    assign portb_den_pb_we = pb_wr_in && pb_port_in
        && (pb_sel_in == `GLB_SEL_DEN); // [RULE1]
    assign portb_lvl_pb_we = pb_wr_in && pb_port_in
        && (pb_sel_in == `GLB_SEL_LVL); // [RULE1]

    // Sole slave on a private bus: never stalls the CPU
    assign lb_ready_out = 1'b1; // [RULE2] [RULE4]

    // Pin drivers
    assign porta_pin_out = porta_lvl;
    assign porta_pin_oe_out = porta_den;
    assign portb_pin_out = portb_lvl;
    assign portb_pin_oe_out = portb_den;

    // Register state shared by both buses
    glb_port_regs #(
        .W(W),
        .RST_VAL(`GLB_DEN_RST)
    ) u_porta_den (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .ce_in(ce_in),
        .lb_we_in(porta_den_lb_we),
        .lb_op_in(lb_op),
        .lb_data_in(lb_wdata_in[W-1:0]),
        .pb_we_in(porta_den_pb_we),
        .pb_op_in(pb_op_in),
        .pb_data_in(pb_wdata_in[W-1:0]),
        .value_out(porta_den)
    ); // [RULE1] [RULE5] [RULE6]

    glb_port_regs #(
        .W(W),
        .RST_VAL(`GLB_LVL_RST)
    ) u_porta_lvl (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .ce_in(ce_in),
        .lb_we_in(porta_lvl_lb_we),
        .lb_op_in(lb_op),
        .lb_data_in(lb_wdata_in[W-1:0]),
        .pb_we_in(porta_lvl_pb_we),
        .pb_op_in(pb_op_in),
        .pb_data_in(pb_wdata_in[W-1:0]),
        .value_out(porta_lvl)
    ); // [RULE1] [RULE7]

    glb_port_regs #(
        .W(W),
        .RST_VAL(`GLB_DEN_RST)
    ) u_portb_den (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .ce_in(ce_in),
        .lb_we_in(portb_den_lb_we),
        .lb_op_in(lb_op),
        .lb_data_in(lb_wdata_in[W-1:0]),
        .pb_we_in(portb_den_pb_we),
        .pb_op_in(pb_op_in),
        .pb_data_in(pb_wdata_in[W-1:0]),
        .value_out(portb_den)
    ); // [RULE1] [RULE9]

    glb_port_regs #(
        .W(W),
        .RST_VAL(`GLB_LVL_RST)
    ) u_portb_lvl (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .ce_in(ce_in),
        .lb_we_in(portb_lvl_lb_we),
        .lb_op_in(lb_op),
        .lb_data_in(lb_wdata_in[W-1:0]),
        .pb_we_in(portb_lvl_pb_we),
        .pb_op_in(pb_op_in),
        .pb_data_in(pb_wdata_in[W-1:0]),
        .value_out(portb_lvl)
    ); // [RULE1] [RULE9]

    // Sampled pin levels
    glb_pin_sample #(
        .W(W)
    ) u_porta_pins (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .ce_in(ce_in),
        .pin_in(porta_pin_in),
        .level_out(porta_pins)
    );

    glb_pin_sample #(
        .W(W)
    ) u_portb_pins (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .ce_in(ce_in),
        .pin_in(portb_pin_in),
        .level_out(portb_pins)
    );

    // Local bus read data
    always @* begin
        lb_rdata_nxt = 32'h00000000;
        if (lb_rd_ok) begin
            lb_rdata_nxt = lb_port ? widen(portb_pins)
                                   : widen(porta_pins); // [RULE8] [RULE9]
        end
    end

    // Peripheral bus read data: every register readable
    always @* begin
        case (pb_sel_in)
            `GLB_SEL_DEN:
                pb_rdata_nxt = pb_port_in ? widen(portb_den)
                                          : widen(porta_den); // [RULE1]
            `GLB_SEL_LVL:
                pb_rdata_nxt = pb_port_in ? widen(portb_lvl)
                                          : widen(porta_lvl); // [RULE1]
            `GLB_SEL_PIN:
                pb_rdata_nxt = pb_port_in ? widen(portb_pins)
                                          : widen(porta_pins);
            default:
                pb_rdata_nxt = 32'h00000000;
        endcase
    end

    // Answers one cycle after the access, in each cycle with ce_in high
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            lb_rdata_out <= RDATA_RST;
            lb_rvalid_out <= 1'b0;
            lb_err_out <= 1'b0;
            pb_rdata_out <= RDATA_RST;
            pb_rvalid_out <= 1'b0;
        end else if (ce_in) begin
            lb_rdata_out <= lb_rdata_nxt; // [RULE3] [RULE4]
            lb_rvalid_out <= lb_rd_in;
            lb_err_out <= lb_bad; // [RULE11]
            if (pb_rd_in) begin
                pb_rdata_out <= pb_rdata_nxt;
            end
            pb_rvalid_out <= pb_rd_in;
        end
    end

endmodule // glb_port

`default_nettype wire

/* src/glb_port_regs.v */
`timescale 1ns/1ps
`default_nettype none
`include "glb_consts.vh"

module glb_port_regs #(
    parameter W = 32,
    parameter [31:0] RST_VAL = `GLB_DEN_RST
) (
    input wire clk_in,
    input wire nrst_in,
    input wire ce_in,
    input wire lb_we_in,
    input wire [1:0] lb_op_in,
    input wire [W-1:0] lb_data_in,
    input wire pb_we_in,
    input wire [1:0] pb_op_in,
    input wire [W-1:0] pb_data_in,
    output reg [W-1:0] value_out
);

    localparam [W-1:0] RST_W = RST_VAL[W-1:0];

    reg [W-1:0] value_nxt;
    reg [W-1:0] after_lb;

    function [W-1:0] apply_op;
        input [W-1:0] cur;
        input [1:0] op;
        input [W-1:0] data;
        begin
            case (op)
                `GLB_OP_WRITE: apply_op = data;
                `GLB_OP_SET: apply_op = cur | data;
                `GLB_OP_CLEAR: apply_op = cur & ~data;
                `GLB_OP_TOGGLE: apply_op = cur ^ data;
                default: apply_op = cur;
            endcase
        end
    endfunction

    // Local bus op first, then peripheral bus op on its result
    always @* begin
        after_lb = lb_we_in ? apply_op(value_out, lb_op_in, lb_data_in)
                            : value_out; // [RULE10]
        value_nxt = pb_we_in ? apply_op(after_lb, pb_op_in, pb_data_in)
                             : after_lb; // [RULE1]
    end

    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            value_out <= RST_W;
        end else if (ce_in) begin
            value_out <= value_nxt;
        end
    end

endmodule // glb_port_regs

`default_nettype wire

/* tb/glb_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module glb_cpu_model (
    input wire logic clk_in,
    input wire logic [31:0] rdata_in,
    input wire logic rvalid_in,
    input wire logic err_in,
    output logic [31:0] addr_out,
    output logic wr_out,
    output logic rd_out,
    output logic [31:0] wdata_out
);
    initial begin
        addr_out = 32'h00000000;
        wdata_out = 32'h00000000;
        wr_out = 1'b0;
        rd_out = 1'b0;
    end
    // Released strobes go low; address and data lines show the inverse of their last value
    function automatic void rel();
        wr_out = 1'b0;
        rd_out = 1'b0;
        addr_out = ~addr_out;
        wdata_out = ~wdata_out;
    endfunction
    task automatic idle();
        @(posedge clk_in);
        #1;
        rel();
    endtask
    // Alias places only get writes
    task automatic write(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_in);
        #1;
        rd_out = 1'b0;
        wr_out = 1'b1;
        addr_out = a;
        wdata_out = d;
    endtask
    task automatic read(input logic [31:0] a, output logic [31:0] d,
        output logic [1:0] r);
        @(posedge clk_in);
        #1;
        wr_out = 1'b0;
        rd_out = 1'b1;
        addr_out = a;
        @(posedge clk_in);
        #1;
        d = rdata_in;
        r = {rvalid_in, err_in};
        rel();
    endtask
endmodule // glb_cpu_model
`default_nettype wire

/* tb/glb_port_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "glb_consts.vh"
module glb_port_monitor #(parameter W = 32) (
    input wire clk_in,
    input wire nrst_in,
    input wire ce_in,
    input wire [31:0] lb_addr_in,
    input wire lb_wr_in,
    input wire lb_rd_in,
    input wire [31:0] lb_wdata_in,
    input wire lb_ready_out,
    input wire [31:0] lb_rdata_out,
    input wire lb_rvalid_out,
    input wire lb_err_out,
    input wire pb_wr_in,
    input wire [W-1:0] porta_pin_out,
    input wire [W-1:0] porta_pin_oe_out,
    input wire [W-1:0] portb_pin_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    wire lw = ce_in && lb_wr_in && !pb_wr_in;
    wire lr = ce_in && lb_rd_in && !lb_wr_in;
    wire [W-1:0] wd = lb_wdata_in[W-1:0];
    sequence s_rd_ok;
        lb_rvalid_out && !lb_err_out;
    endsequence
    sequence s_rd_bad;
        lb_rvalid_out && lb_err_out && lb_rdata_out == 32'h00000000;
    endsequence
    chk_ready_high: assert property (lb_ready_out)
        else $error("ready low");
    chk_rvalid_cause: assert property (
        ce_in && !lb_rd_in |=> !lb_rvalid_out) else $error("stray rvalid");
    chk_pin_read: assert property (
        lr && lb_addr_in == `GLB_PA_PIN |=> s_rd_ok)
        else $error("pin read answer");
    chk_alias_read: assert property (
        lr && lb_addr_in == `GLB_PA_DEN_TGL |=> s_rd_bad)
        else $error("alias read answer");
    chk_den_set: assert property (
        lw && lb_addr_in == `GLB_PA_DEN_SET |=>
        porta_pin_oe_out == $past(porta_pin_oe_out | wd)) else $error("set");
    chk_lvl_tgl: assert property (
        lw && lb_addr_in == `GLB_PA_LVL_TGL |=>
        porta_pin_out == $past(porta_pin_out ^ wd)) else $error("toggle");
    chk_b_lvl_clr: assert property (
        lw && lb_addr_in == `GLB_PB_LVL_CLR |=>
        portb_pin_out == $past(portb_pin_out & ~wd)) else $error("clear");
    chk_pin_wr_err: assert property (
        lw && lb_addr_in == `GLB_PA_PIN |=>
        lb_err_out && $stable(porta_pin_out)) else $error("pin write");
endmodule // glb_port_monitor
`default_nettype wire

/* tb/tb_glb_port.sv */
`timescale 1ns/1ps
`default_nettype none
`include "glb_consts.vh"
module tb_glb_port;
    logic clk_in, nrst_in, wr, rd, rvalid, err, rdy, pport, pwr, prd, pval;
    logic [31:0] addr, wdata, rdata, pwdata, prdata, a, got;
    logic [31:0] pa_in, pb_in, pa_out, pa_oe, pb_out, pb_oe;
    logic [1:0] psel, pop, resp;
    logic ce_in;
    int num_errors = 0;
    int num_checks = 0;
    logic [31:0] row_data [16] = '{32'h0000F0F0, 32'h0000000F, 32'h000000F0,
        32'hFFFF0000, 32'h12345678, 32'h80000001, 32'h12345678, 32'h0000000F,
        32'hA5A5A5A5, 32'h0000005A, 32'hFF000000, 32'h000000FF,
        32'h0F0F0F0F, 32'hF0000000, 32'h0F000000, 32'hFFFFFFFF};
    logic [31:0] row_exp [16] = '{32'h0000F0F0, 32'h0000F0FF, 32'h0000F00F,
        32'hFFFFF00F, 32'h12345678, 32'h92345679, 32'h80000001, 32'h8000000E,
        32'hA5A5A5A5, 32'hA5A5A5FF, 32'h00A5A5FF, 32'h00A5A500,
        32'h0F0F0F0F, 32'hFF0F0F0F, 32'hF00F0F0F, 32'h0FF0F0F0};
    glb_port #(.W(32)) glb_port_inst (.clk_in(clk_in), .nrst_in(nrst_in),
        .ce_in(ce_in), .lb_addr_in(addr), .lb_wr_in(wr), .lb_rd_in(rd),
        .lb_wdata_in(wdata), .lb_ready_out(rdy), .lb_rdata_out(rdata),
        .lb_rvalid_out(rvalid), .lb_err_out(err), .pb_port_in(pport),
        .pb_sel_in(psel), .pb_op_in(pop), .pb_wr_in(pwr), .pb_rd_in(prd),
        .pb_wdata_in(pwdata), .pb_rdata_out(prdata), .pb_rvalid_out(pval),
        .porta_pin_in(pa_in), .porta_pin_out(pa_out),
        .porta_pin_oe_out(pa_oe), .portb_pin_in(pb_in),
        .portb_pin_out(pb_out), .portb_pin_oe_out(pb_oe));
    glb_cpu_model glb_cpu_model_inst (.clk_in(clk_in), .rdata_in(rdata),
        .rvalid_in(rvalid), .err_in(err), .addr_out(addr), .wr_out(wr),
        .rd_out(rd), .wdata_out(wdata));
    task automatic chk(input string n, input logic [31:0] s,
        input logic [31:0] x);
        num_checks++;
        if (s !== x) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic test_done();
        if (num_errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    function automatic logic [31:0] obs(input logic [31:0] x);
        return x[8] ? (x[4] ? pb_out : pb_oe) : (x[4] ? pa_out : pa_oe);
    endfunction
    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    initial begin
        #20000;
        num_errors++;
        test_done();
    end
    initial begin
        nrst_in = 1'b0;
        ce_in = 1'b1;
        {pport, pwr, prd, psel, pop} = 7'h00;
        pwdata = 32'h00000000;
        pa_in = 32'hCAFE0001;
        pb_in = 32'h0BAD0F00;
        repeat (12) @(posedge clk_in);
        #1 nrst_in = 1'b1;
        chk("reset", pa_oe | pa_out | pb_oe | pb_out,
            32'h00000000);
        chk("ready", {31'h0, rdy}, 32'h1);
        for (int i = 0; i < 16; i++) begin
            a = 32'h40000040 | (i[3] << 8) | (i[2] << 4) | (i[1:0] << 2);
            glb_cpu_model_inst.write(a, row_data[i]);
            glb_cpu_model_inst.idle();
            chk("alias", obs(a),
                row_exp[i]);
        end
        glb_cpu_model_inst.write(`GLB_PA_LVL_SET, 32'h00000001);
        glb_cpu_model_inst.write(`GLB_PA_LVL_SET, 32'h00000010);
        glb_cpu_model_inst.write(`GLB_PA_PIN, 32'hFFFFFFFF);
        glb_cpu_model_inst.idle();
        chk("back_to_back", pa_out, 32'h8000001F);
        glb_cpu_model_inst.read(`GLB_PA_PIN, got, resp);
        chk("pin_a", got, 32'hCAFE0001);
        chk("resp_a", {30'h0, resp}, 32'h2);
        glb_cpu_model_inst.read(`GLB_PB_PIN, got, resp);
        chk("pin_b", got, 32'h0BAD0F00);
        glb_cpu_model_inst.read(`GLB_PA_DEN_TGL, got, resp);
        chk("alias_rd", {got[29:0], resp}, 32'h3);
        glb_cpu_model_inst.read(32'h40000064, got, resp);
        chk("unmapped", {30'h0, resp}, 32'h3);
        @(posedge clk_in);
        #1 {pport, psel, pop, pwr} = 6'h0B;
        pwdata = 32'h00000100;
        @(posedge clk_in);
        #1 pwr = 1'b0;
        prd = 1'b1;
        @(posedge clk_in);
        #1 prd = 1'b0;
        chk("shared", prdata, 32'h8000011F);
        chk("shared_pin", pa_out, 32'h8000011F);
        chk("shared_valid", {31'h0, pval}, 32'h1);
        ce_in = 1'b0;
        glb_cpu_model_inst.write(`GLB_PA_LVL_WR, 32'h00000000);
        glb_cpu_model_inst.idle();
        chk("ce_hold", pa_out, 32'h8000011F);
        ce_in = 1'b1;
        nrst_in = 1'b0;
        glb_cpu_model_inst.idle();
        nrst_in = 1'b1;
        chk("mid_reset", pa_oe | pa_out | pb_oe | pb_out | prdata,
            32'h00000000);
        glb_cpu_model_inst.write(`GLB_PA_DEN_WR, 32'h00000003);
        glb_cpu_model_inst.idle();
        chk("after_reset", pa_oe, 32'h00000003);
        test_done();
    end
endmodule // tb_glb_port
bind glb_port glb_port_monitor #(.W(W)) glb_port_monitor_inst (
    .clk_in(clk_in), .nrst_in(nrst_in), .ce_in(ce_in),
    .lb_addr_in(lb_addr_in), .lb_wr_in(lb_wr_in), .lb_rd_in(lb_rd_in),
    .lb_wdata_in(lb_wdata_in), .lb_ready_out(lb_ready_out),
    .lb_rdata_out(lb_rdata_out), .lb_rvalid_out(lb_rvalid_out),
    .lb_err_out(lb_err_out), .pb_wr_in(pb_wr_in),
    .porta_pin_out(porta_pin_out), .porta_pin_oe_out(porta_pin_oe_out),
    .portb_pin_out(portb_pin_out));
`default_nettype wire
